// ==== design/sbt_tap.sv ====
// Boundary-scan test access port of the memory, sampled on ref_clk
// Notes on behaviour
// - Sixteen-state controller, self reset, no reset pin
// - Array contents never reach the scan path
// - Undriven mode and data inputs read as 1
// - Three-bit instruction, bypass, 32-bit id, 107 cells
// - Instruction codes select boundary, id or bypass
// - Floating instructions put data pins at high impedance
// - Extest floats pins instead of driving them
// - Sample keeps data pins driven normally
// - Serial input enters top id cell
// - Bypass cleared on load, keeps last shifted bit
// - Id: revision, configuration, maker code, start bit
// - Configuration encodes density, width, variant flags
// - Serial output changes after test clock falls
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_tap #(
   parameter logic [1:0]  WIDTH_CODE = `SBT_ID_WIDTH_X18,
   parameter logic        FLAG_T     = 1'b1,
   parameter logic        FLAG_Q     = 1'b1,
   parameter logic        FLAG_B     = 1'b0,
   parameter logic        FLAG_S     = 1'b1,
   parameter logic [10:0] MAKER_CODE = 11'h155 // Arbitrary value
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rstn,
   input  wire logic                    tck,
   input  wire logic                    tms,
   input  wire logic                    tms_oe_n,
   input  wire logic                    tdi,
   input  wire logic                    tdi_oe_n,
   output logic                         tdo,
   output logic                         tdo_oe_n,
   input  wire logic [`SBT_BSR_LEN-1:0] pad_in,
   output logic                         dq_float,
   output sbt_pkg::sbt_state_t          tap_state,
   output logic [`SBT_INSN_W-1:0]       test_instruction_bits
);
   import sbt_pkg::*;

   logic                    tck_s;
   logic                    tms_s;
   logic                    tdi_s;
   logic                    tck_d_r;
   logic                    tck_rise;
   logic                    tck_fall;
   logic                    tms_eff;
   logic                    tdi_eff;
   sbt_state_t              st_r;
   sbt_state_t              st_nxt;
   logic [`SBT_INSN_W-1:0]  ir_sh_r;
   logic [`SBT_INSN_W-1:0]  ir_r;
   logic                    byp_r;
   logic                    byp_sel;
   logic [`SBT_ID_W-1:0]    id_r;
   logic [`SBT_BSR_LEN-1:0] bsr_r;
   logic                    sdo;
   logic [`SBT_ID_W-1:0]    id_val;
   logic [16:0]             cfg;

   // Undriven inputs read as 1: the enable input flags a floating pin
   assign tms_eff = tms_oe_n ? 1'b1 : tms;
   assign tdi_eff = tdi_oe_n ? 1'b1 : tdi;

   sbt_sync #(.INIT(1'b0)) u_sck (.ref_clk(ref_clk), .rstn(rstn),
      .d(tck), .q(tck_s));
   sbt_sync #(.INIT(1'b1)) u_sms (.ref_clk(ref_clk), .rstn(rstn),
      .d(tms_eff), .q(tms_s));
   sbt_sync #(.INIT(1'b1)) u_sdi (.ref_clk(ref_clk), .rstn(rstn),
      .d(tdi_eff), .q(tdi_s));

   // Edge finder on the synchronised test clock
   always_ff @(posedge ref_clk) begin
      if (!rstn) tck_d_r <= 1'b0;
      else       tck_d_r <= tck_s;
   end
   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;

   // Part configuration 00def0wx0t0q0b0s0
   assign cfg = {2'b00, `SBT_ID_DENSITY, 1'b0, WIDTH_CODE, 1'b0, FLAG_T,
                 1'b0, FLAG_Q, 1'b0, FLAG_B, 1'b0, FLAG_S, 1'b0};
   assign id_val = {`SBT_ID_REV, cfg, MAKER_CODE, 1'b1};

   // Sixteen-state controller walk
   always_comb begin
      unique case (st_r)
         SBT_RESET:  st_nxt = tms_s ? SBT_RESET  : SBT_IDLE;
         SBT_IDLE:   st_nxt = tms_s ? SBT_SEL_DR : SBT_IDLE;
         SBT_SEL_DR: st_nxt = tms_s ? SBT_SEL_IR : SBT_CAP_DR;
         SBT_CAP_DR: st_nxt = tms_s ? SBT_EX1_DR : SBT_SH_DR;
         SBT_SH_DR:  st_nxt = tms_s ? SBT_EX1_DR : SBT_SH_DR;
         SBT_EX1_DR: st_nxt = tms_s ? SBT_UPD_DR : SBT_PAU_DR;
         SBT_PAU_DR: st_nxt = tms_s ? SBT_EX2_DR : SBT_PAU_DR;
         SBT_EX2_DR: st_nxt = tms_s ? SBT_UPD_DR : SBT_SH_DR;
         SBT_UPD_DR: st_nxt = tms_s ? SBT_SEL_DR : SBT_IDLE;
         SBT_SEL_IR: st_nxt = tms_s ? SBT_RESET  : SBT_CAP_IR;
         SBT_CAP_IR: st_nxt = tms_s ? SBT_EX1_IR : SBT_SH_IR;
         SBT_SH_IR:  st_nxt = tms_s ? SBT_EX1_IR : SBT_SH_IR;
         SBT_EX1_IR: st_nxt = tms_s ? SBT_UPD_IR : SBT_PAU_IR;
         SBT_PAU_IR: st_nxt = tms_s ? SBT_EX2_IR : SBT_PAU_IR;
         SBT_EX2_IR: st_nxt = tms_s ? SBT_UPD_IR : SBT_SH_IR;
         SBT_UPD_IR: st_nxt = tms_s ? SBT_SEL_DR : SBT_IDLE;
      endcase
   end

   // State register; rstn models the power-up self reset
   always_ff @(posedge ref_clk) begin
      if (!rstn)         st_r <= SBT_RESET;
      else if (tck_rise) st_r <= st_nxt;
   end
   assign tap_state = st_r;

   // Instruction shift stage and active instruction
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ir_sh_r <= `SBT_CAPTURE_INSN;
         ir_r    <= `SBT_OP_IDCODE;
      end else if (tck_rise) begin
         unique case (st_r)
            SBT_CAP_IR: ir_sh_r <= `SBT_CAPTURE_INSN;
            SBT_SH_IR:  ir_sh_r <= {tdi_s, ir_sh_r[`SBT_INSN_W-1:1]};
            default:    ir_sh_r <= ir_sh_r;
         endcase
         if (st_r == SBT_RESET)       ir_r <= `SBT_OP_IDCODE;
         else if (st_r == SBT_UPD_IR) ir_r <= ir_sh_r;
      end
   end
   assign test_instruction_bits = ir_r;

   // Reserved codes fall back to the bypass bit, so it must move too
   assign byp_sel = (ir_r != `SBT_OP_EXTEST) && (ir_r != `SBT_OP_SAMPLEZ) &&
                    (ir_r != `SBT_OP_SAMPLE) && (ir_r != `SBT_OP_IDCODE);

   // Bypass bit: zero on load and capture, holds last shifted bit
   always_ff @(posedge ref_clk) begin
      if (!rstn) byp_r <= 1'b0;
      else if (tck_rise && st_r == SBT_UPD_IR &&
               ir_sh_r == `SBT_OP_BYPASS) byp_r <= 1'b0;
      else if (tck_rise && byp_sel) begin
         if (st_r == SBT_CAP_DR)     byp_r <= 1'b0;
         else if (st_r == SBT_SH_DR) byp_r <= tdi_s;
      end
   end

   // Id register: input enters top cell, shifts toward the output
   always_ff @(posedge ref_clk) begin
      if (!rstn) id_r <= '0;
      else if (tck_rise && ir_r == `SBT_OP_IDCODE) begin
         if (st_r == SBT_CAP_DR)     id_r <= id_val;
         else if (st_r == SBT_SH_DR)
            id_r <= {tdi_s, id_r[`SBT_ID_W-1:1]};
      end
   end

   // Boundary cells capture pad levels, except cell 47 which loads zero, never array data
   always_ff @(posedge ref_clk) begin
      if (!rstn) bsr_r <= '0;
      else if (tck_rise && (ir_r == `SBT_OP_EXTEST ||
               ir_r == `SBT_OP_SAMPLEZ || ir_r == `SBT_OP_SAMPLE)) begin
         if (st_r == SBT_CAP_DR) begin
            bsr_r <= pad_in;
            bsr_r[`SBT_BSR_INT_POS-1] <= 1'b0;
         end else if (st_r == SBT_SH_DR)
            bsr_r <= {tdi_s, bsr_r[`SBT_BSR_LEN-1:1]};
      end
   end

   // Serial source follows the active instruction; reserved codes bypass
   always_comb begin
      unique case (ir_r)
         `SBT_OP_EXTEST, `SBT_OP_SAMPLEZ, `SBT_OP_SAMPLE: sdo = bsr_r[0];
         `SBT_OP_IDCODE: sdo = id_r[0];
         default:        sdo = byp_r;
      endcase
   end

   // Output moves on the falling test clock, enabled only while shifting
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         tdo      <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo      <= (st_r == SBT_SH_IR) ? ir_sh_r[0] : sdo;
         tdo_oe_n <= !(st_r == SBT_SH_IR || st_r == SBT_SH_DR);
      end
   end

   // Float the data pins for extest and floating sample, not for sample
   always_ff @(posedge ref_clk) begin
      if (!rstn) dq_float <= 1'b0;
      else dq_float <= (ir_r == `SBT_OP_EXTEST) ||
                       (ir_r == `SBT_OP_SAMPLEZ);
   end

   a_float_follows_insn: assert property (@(posedge ref_clk)
      disable iff (!rstn) (ir_r == `SBT_OP_SAMPLE) |=> !dq_float)
      else $error("data pins floated under sample");
   a_extest_floats: assert property (@(posedge ref_clk)
      disable iff (!rstn) (ir_r == `SBT_OP_EXTEST) |=> dq_float)
      else $error("extest did not float pins");
   a_samplez_floats: assert property (@(posedge ref_clk)
      disable iff (!rstn) (ir_r == `SBT_OP_SAMPLEZ) |=> dq_float)
      else $error("floating sample did not float pins");
   a_tdo_idle_hiz: assert property (@(posedge ref_clk)
      disable iff (!rstn) (tck_fall && st_r == SBT_IDLE) |=> tdo_oe_n)
      else $error("serial output driven outside shift");
   a_tdo_shift_on: assert property (@(posedge ref_clk)
      disable iff (!rstn) (tck_fall && st_r == SBT_SH_DR) |=> !tdo_oe_n)
      else $error("serial output not driven in shift");
   a_tdo_fall_only: assert property (@(posedge ref_clk)
      disable iff (!rstn) !$past(tck_fall) |-> $stable(tdo))
      else $error("serial output moved without falling edge");
   a_reset_by_tms: assert property (@(posedge ref_clk)
      disable iff (!rstn) (tck_rise && tms_s && st_r == SBT_SEL_IR)
      |=> st_r == SBT_RESET)
      else $error("controller missed reset state");
   a_bypass_clear: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (tck_rise && ir_r == `SBT_OP_BYPASS && st_r == SBT_CAP_DR) |=> !byp_r)
      else $error("bypass bit not cleared");
   a_bypass_load: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (tck_rise && st_r == SBT_UPD_IR && ir_sh_r == `SBT_OP_BYPASS)
      |=> !byp_r)
      else $error("bypass bit not cleared on load");
   a_id_start_bit: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (tck_rise && ir_r == `SBT_OP_IDCODE && st_r == SBT_CAP_DR)
      |=> id_r[0] && id_r[31:29] == `SBT_ID_REV)
      else $error("id capture wrong");
   a_id_shift_in: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (tck_rise && ir_r == `SBT_OP_IDCODE && st_r == SBT_SH_DR)
      |=> id_r[31] == $past(tdi_s))
      else $error("id shift input wrong");
   a_undriven_tms: assert property (@(posedge ref_clk)
      disable iff (!rstn) tms_oe_n [*3] |-> tms_s)
      else $error("floating mode input not read as one");
endmodule : sbt_tap

// ==== design/sbt_params.svh ====
// Constants of the scan test port: codes, widths, field values, timing
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
`define SBT_INSN_W        3
`define SBT_ID_W          32
`define SBT_BSR_LEN       107
`define SBT_BSR_INT_POS   48
`define SBT_OP_EXTEST     3'h0
`define SBT_OP_IDCODE     3'h1
`define SBT_OP_SAMPLEZ    3'h2
`define SBT_OP_SAMPLE     3'h4
`define SBT_OP_BYPASS     3'h7
`define SBT_CAPTURE_INSN  3'h1
`define SBT_ID_REV        3'h0
`define SBT_ID_DENSITY    3'h1
`define SBT_ID_WIDTH_X36  2'h3
`define SBT_ID_WIDTH_X18  2'h2
`define SBT_ID_WIDTH_X9   2'h0
`define SBT_TDO_VALID_NS  10
`define SBT_CLK_NS        40
`define SBT_TDO_VALID_CYC ((`SBT_TDO_VALID_NS / `SBT_CLK_NS) < 1 ? 1 : \
                           (`SBT_TDO_VALID_NS / `SBT_CLK_NS))
`endif

// ==== design/sbt_pkg.sv ====
// Types of the scan test port
package sbt_pkg;
   typedef enum logic [3:0] {
      SBT_RESET   = 4'h0,
      SBT_IDLE    = 4'h1,
      SBT_SEL_DR  = 4'h2,
      SBT_CAP_DR  = 4'h3,
      SBT_SH_DR   = 4'h4,
      SBT_EX1_DR  = 4'h5,
      SBT_PAU_DR  = 4'h6,
      SBT_EX2_DR  = 4'h7,
      SBT_UPD_DR  = 4'h8,
      SBT_SEL_IR  = 4'h9,
      SBT_CAP_IR  = 4'ha,
      SBT_SH_IR   = 4'hb,
      SBT_EX1_IR  = 4'hc,
      SBT_PAU_IR  = 4'hd,
      SBT_EX2_IR  = 4'he,
      SBT_UPD_IR  = 4'hf
   } sbt_state_t;
endpackage : sbt_pkg

// ==== design/sbt_sync.sv ====
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sbt_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sbt_sync

// ==== testbench/sbt_ctl_model.sv ====
// Model of the board scan controller that drives the test port pins
`timescale 1ns/1ps
module sbt_ctl_model (
   input  wire logic ref_clk,
   input  wire logic tdo,
   output logic      tck,
   output logic      tms,
   output logic      tms_oe_n,
   output logic      tdi,
   output logic      tdi_oe_n
);
   // Test clock stands low between bits, lines driven high at start
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tms_oe_n = 1'b0;
      tdi = 1'b1;
      tdi_oe_n = 1'b0;
   end

   // One 320 ns test clock; tdo sampled early and late in the high phase
   task automatic clk_bit(input logic drv, input logic m, input logic d,
                          output logic o1, output logic o2);
      tms_oe_n <= ~drv;
      tdi_oe_n <= ~drv;
      tms <= drv ? m : ~tms; // A released line shows no stale level
      tdi <= drv ? d : ~tdi;
      repeat (4) @(posedge ref_clk);
      #1 tck <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 o1 = tdo;
      repeat (2) @(posedge ref_clk);
      #1 o2 = tdo;
      tck <= 1'b0;
   endtask : clk_bit
endmodule : sbt_ctl_model

// ==== testbench/sbt_tap_tb.sv ====
// Self-checking bench of the scan test port
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_tap_tb;
   import sbt_pkg::*;
   localparam logic [10:0]  MAKER = 11'h2a3; // Arbitrary value
   localparam logic [16:0]  CFG   = 17'b0_0001_0100_1010_0010;
   localparam logic [31:0]  ID    = {`SBT_ID_REV, CFG, MAKER, 1'b1};
   localparam logic [106:0] PAD   = 107'h4d2_5a3c_96f0_e1d2_c3b4_a596_8778;
   localparam logic [127:0] PAT   =
      128'h93c5_e17a_4b2d_f068_1e9c_7a35_d24b_86f1;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic tck, tms, tms_oe_n, tdi, tdi_oe_n, tdo, tdo_oe_n, dq_float;
   logic [106:0] pad_in = PAD;
   logic [2:0]   test_instruction_bits;
   sbt_state_t   tap_state;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   sbt_tap #(.WIDTH_CODE(`SBT_ID_WIDTH_X18), .FLAG_T(1'b1), .FLAG_Q(1'b1),
      .FLAG_B(1'b0), .FLAG_S(1'b1), .MAKER_CODE(MAKER)) u_dut (
      .ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms),
      .tms_oe_n(tms_oe_n), .tdi(tdi), .tdi_oe_n(tdi_oe_n), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .pad_in(pad_in), .dq_float(dq_float),
      .tap_state(tap_state), .test_instruction_bits(test_instruction_bits));
   sbt_ctl_model u_ctl (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms),
      .tms_oe_n(tms_oe_n), .tdi(tdi), .tdi_oe_n(tdi_oe_n));

   // 25 MHz clock and a cycle ceiling well above the run length
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   task automatic cmp1(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask : cmp1
   task automatic cmpv(input string n, input logic [127:0] e,
                       input logic [127:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : cmpv

   // One test clock; tdo must not move while the test clock is high
   task automatic bit_io(input logic drv, input logic m, input logic d,
                         output logic o);
      logic o1;
      u_ctl.clk_bit(drv, m, d, o1, o);
      cmp1("tdo steady", o1, o);
   endtask : bit_io
   task automatic walk(input logic [9:0] s, input int n);
      logic o;
      for (int i = 0; i < n; i++) bit_io(1'b1, s[i], 1'b1, o);
   endtask : walk

   // Reset by five ones, shift an instruction in, check its effects
   task automatic load_ir(input logic [2:0] c);
      logic [2:0] cap;
      logic o;
      walk(10'b0011011111, 10);
      for (int i = 0; i < 3; i++) begin
         bit_io(1'b1, i == 2, c[i], o);
         cap[i] = o;
      end
      cmpv("captured insn", 3'b001, cap);
      walk(10'b0000000001, 2);
      repeat (2) @(posedge ref_clk);
      #1 cmpv("insn", c, test_instruction_bits);
      cmp1("dq_float", c == 3'h0 || c == 3'h2, dq_float);
   endtask : load_ir

   // Data scan of n cells followed by eight pattern bits from tdi
   task automatic dr_scan(input int n, input logic [127:0] cap);
      logic [127:0] got, exp;
      logic o;
      got = '0;
      exp = '0;
      walk(10'b0000000001, 3);
      for (int i = 0; i < n + 8; i++) begin
         bit_io(1'b1, i == n + 7, PAT[i], o);
         if (i == 0) cmp1("tdo_oe_n shift", 1'b0, tdo_oe_n);
         got[i] = o;
         exp[i] = (i < n) ? cap[i] : PAT[i-n];
      end
      cmpv("dr scan", exp, got);
      walk(10'b0000000001, 2);
      cmp1("tdo_oe_n idle", 1'b1, tdo_oe_n);
   endtask : dr_scan

   task automatic test_idcode;
      load_ir(`SBT_OP_IDCODE);
      dr_scan(32, {96'h0, ID});
   endtask : test_idcode

   // Every documented code but id, with its scan length; reserved
   // codes are never sent, as the controller must not use them
   task automatic test_codes;
      logic [127:0] bsr;
      bsr = {21'h0, PAD};
      bsr[47] = 1'b0;
      for (int c = 0; c < 8; c++) begin
         if (c == 0 || c == 2 || c == 4 || c == 7) begin
            load_ir(3'(c));
            if (c != 7) dr_scan(107, bsr);
            else dr_scan(1, 128'h0);
         end
      end
   endtask : test_codes

   // Undriven mode line must act as 1 even though the wire toggles
   task automatic test_release;
      logic o;
      load_ir(`SBT_OP_BYPASS);
      for (int i = 0; i < 5; i++) bit_io(1'b0, 1'b0, 1'b0, o);
      repeat (2) @(posedge ref_clk);
      #1 cmpv("state", SBT_RESET, tap_state);
      cmpv("insn", `SBT_OP_IDCODE, test_instruction_bits);
   endtask : test_release

   task automatic final_report;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   // Reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 cmpv("state", SBT_RESET, tap_state);
      cmpv("insn", `SBT_OP_IDCODE, test_instruction_bits);
      cmp1("dq_float", 1'b0, dq_float);
      test_idcode();
      test_codes();
      test_release();
      final_report();
   end
endmodule : sbt_tap_tb
